// [panel_button.v]
// pushbutton press and release edge detector
`timescale 1ns/10ps
module panel_button (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // button level, high while held
  input wire level,
  // one-cycle edges
  output wire press,
  output wire release_ev
);
  reg prev; // level one cycle ago

  // remember last level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign press = level & ~prev;
  assign release_ev = ~level & prev;
endmodule

// [panel_defines.vh]
// constants for the trip unit front-panel test sequencer
`ifndef PANEL_DEFINES_VH
`define PANEL_DEFINES_VH
// timing
`define CLK_PERIOD_NS 20
`define TENTH_SEC_NS 100000000
`define TICK_CYCLES (`TENTH_SEC_NS / `CLK_PERIOD_NS)
`define ELAPSED_MAX 10'h03E7
// register offsets
`define REG_PICKUP_LD 6'h00
`define REG_PICKUP_SD 6'h04
`define REG_PICKUP_INST 6'h08
`define REG_PICKUP_GND 6'h0C
`define REG_DELAY_LD 6'h10
`define REG_DELAY_SD 6'h14
`define REG_DELAY_GND 6'h18
`define REG_PLUG 6'h1C
`define REG_STATUS 6'h20
`define REG_ELAPSED 6'h24
`define REG_INT_STAT 6'h28
`define REG_INT_MASK 6'h2C
// reset values
`define RST_PICKUP 8'hFF
`define RST_DELAY 12'h000
`define RST_PLUG 8'h00
`define RST_MASK 4'h0
// selector positions
`define SEL_X1 3'h0
`define SEL_X2 3'h1
`define SEL_X3 3'h2
`define SEL_PHASE_TRIP 3'h3
`define SEL_X8 3'h4
`define SEL_X10 3'h5
`define SEL_GND_CHECK 3'h6
`define SEL_GND_TRIP 3'h7
// simulated test levels, tenths of plug rating
`define LVL_X1 8'h0A
`define LVL_X2 8'h14
`define LVL_X3 8'h1E
`define LVL_X6 8'h3C
`define LVL_X8 8'h50
`define LVL_X10 8'h64
`define LVL_GND 8'h0A
// load abort threshold, percent of plug rating
`define LOAD_ABORT_PCT 8'h28
// function index / led bit / cause code
`define FN_LD 2'h0
`define FN_SD 2'h1
`define FN_INST 2'h2
`define FN_GND 2'h3
// pointer positions
`define PTR_PHASE_A 2'h0
`define PTR_GROUND 2'h3
// display modes
`define DISP_BLANK 2'h0
`define DISP_TIME 2'h1
`define DISP_MSG 2'h2
`define DISP_CURRENT 2'h3
// interrupt bits
`define IRQ_DONE 0
`define IRQ_TRIP 1
`define IRQ_ABORT 2
`define IRQ_FAULT 3
`endif

// [panel_operator.sv]
// operator model that works the front-panel pushbuttons
`timescale 1ns/10ps
module panel_operator (
  // clock
  input wire clk,
  // pushbutton levels, high while held
  output wire test_btn,
  output wire step_btn,
  output wire reset_btn,
  output wire batt_check_btn
);
  // held buttons: 0 test, 1 step, 2 trip reset, 3 battery check
  reg [3:0] held = 4'h0;
  assign {batt_check_btn, reset_btn, step_btn, test_btn} = held;
  ////////////////////////////////////////////////////////////////////////////
  // change one button after an edge, then let the panel react
  task hold(input int b, input bit v);
    @(posedge clk);
    held[b] <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // full press and release
  task push(input int b);
    hold(b, 1'b1);
    hold(b, 1'b0);
  endtask
endmodule

// [trip_unit_test_panel_sequencer.v]
// front-panel test sequencer of a breaker trip unit
//
// Notes on behaviour
// - test starts on release of test button
// - positions 1,2,3,8,10 and ground check never trip
// - no-trip test lights functions, shows delay
// - step after no-trip keeps delay, no current
// - running clock shown, rolls over after 99.9
// - trip reset after no-trip clears leds, display
// - real fault overrides test and trips breaker
// - trip reset accepted anytime, aborts test
// - only phase and ground trip positions trip
// - test message while held, then running clock
// - trip test trips, lights led, shows code
// - step clears code, shows test current in kA
// - trip positions never show trip time
// - trip reset clears leds, current, pointer home
// - battery led on while check held and healthy
// - cause leds kept without control power
// - load above 40 percent aborts test
`timescale 1ns/10ps
`include "panel_defines.vh"
module trip_unit_test_panel_sequencer #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // register port
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // front panel inputs
  input wire [2:0] selector,
  input wire test_btn,
  input wire step_btn,
  input wire reset_btn,
  input wire batt_check_btn,
  // plant status
  input wire batt_ok,
  input wire ctrl_pwr,
  input wire [7:0] load_pct,
  input wire fault_trip,
  input wire [3:0] fault_cause,
  // panel outputs
  output reg [3:0] func_led,
  output reg [1:0] pointer,
  output reg [1:0] disp_mode,
  output reg [15:0] disp_value,
  output wire test_msg,
  output wire batt_led,
  // breaker and interrupt
  output reg trip_cmd,
  output wire irq
);
  ////////////////////////////////////////////////////////////////
  // states
  localparam S_IDLE = 3'h0;
  localparam S_ARMED = 3'h1;
  localparam S_RUN = 3'h2;
  localparam S_DONE_NT = 3'h3;
  localparam S_DONE_TRIP = 3'h4;

  ////////////////////////////////////////////////////////////////
  // functions
  // simulated test level of a selector position
  function [7:0] test_level;
    input [2:0] sel;
    begin
      case (sel)
        `SEL_X1: test_level = `LVL_X1;
        `SEL_X2: test_level = `LVL_X2;
        `SEL_X3: test_level = `LVL_X3;
        `SEL_PHASE_TRIP: test_level = `LVL_X6;
        `SEL_X8: test_level = `LVL_X8;
        `SEL_X10: test_level = `LVL_X10;
        default: test_level = `LVL_GND;
      endcase
    end
  endfunction

  // ground positions test the ground element only
  function is_ground;
    input [2:0] sel;
    begin
      is_ground = (sel == `SEL_GND_CHECK) || (sel == `SEL_GND_TRIP);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // reset release
  reg rst_s1;
  reg rst_n;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // buttons
  wire test_press;
  wire test_rel;
  wire step_press;
  wire reset_press;
  wire reset_rel;
  panel_button u_test (
    .clk(clk), .rst_n(rst_n), .level(test_btn),
    .press(test_press), .release_ev(test_rel)
  );
  panel_button u_step (
    .clk(clk), .rst_n(rst_n), .level(step_btn),
    .press(step_press), .release_ev()
  );
  panel_button u_reset (
    .clk(clk), .rst_n(rst_n), .level(reset_btn),
    .press(reset_press), .release_ev(reset_rel)
  );

  ////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] pickup_ld; // tenths of plug rating
  reg [7:0] pickup_sd;
  reg [7:0] pickup_inst;
  reg [7:0] pickup_gnd;
  reg [11:0] delay_ld; // tenths of a second
  reg [11:0] delay_sd;
  reg [11:0] delay_gnd;
  reg [7:0] plug; // plug rating, 0.01 kA units
  reg [3:0] int_stat; // sticky events
  reg [3:0] int_mask;
  reg [3:0] events; // one-cycle events this cycle

  // sequencer state
  reg [2:0] state;
  reg [2:0] test_sel; // selector caught at start
  reg [22:0] div_cnt; // tenth-second divider
  reg [9:0] elapsed; // shown clock
  reg [11:0] run_total; // clock without rollover
  reg [1:0] msg_left; // step presses left to clear code
  reg [1:0] cause; // acting function of a trip test

  ////////////////////////////////////////////////////////////////
  // acting function of the latched test
  reg [3:0] below; // functions under test level
  reg [1:0] act_fn;
  reg [11:0] act_delay;
  reg [7:0] lvl;
  always @* begin
    lvl = test_level(test_sel);
    below = 4'h0;
    if (is_ground(test_sel)) begin
      below[`FN_GND] = pickup_gnd < lvl;
    end else begin
      below[`FN_LD] = pickup_ld < lvl;
      below[`FN_SD] = pickup_sd < lvl;
      below[`FN_INST] = pickup_inst < lvl;
    end
    // fastest function acts first
    if (below[`FN_INST]) begin
      act_fn = `FN_INST;
      act_delay = 12'h000;
    end else if (below[`FN_SD]) begin
      act_fn = `FN_SD;
      act_delay = delay_sd;
    end else if (below[`FN_GND]) begin
      act_fn = `FN_GND;
      act_delay = delay_gnd;
    end else begin
      act_fn = `FN_LD;
      act_delay = delay_ld;
    end
  end

  wire trip_pos = (test_sel == `SEL_PHASE_TRIP) || (test_sel == `SEL_GND_TRIP);
  wire tick = (div_cnt == TICK_CYCLES - 1);
  wire busy = (state == S_ARMED) || (state == S_RUN);
  wire overload = load_pct > `LOAD_ABORT_PCT;
  wire abort = busy && (reset_press || overload || fault_trip);
  wire reach = (act_delay == 12'h000) || (tick && (run_total + 12'h001 >= act_delay));
  wire [15:0] test_current = test_level(test_sel) * plug; // 0.001 kA units
  wire ptr_ok = is_ground(test_sel) ? (pointer == `PTR_GROUND) : (pointer == `PTR_PHASE_A);

  assign test_msg = (state == S_ARMED) && trip_pos;
  assign batt_led = batt_check_btn && batt_ok;
  assign irq = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////
  // tenth-second divider, runs only during a test
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 23'h00_0000;
    end else if (state != S_RUN || tick) begin
      div_cnt <= 23'h00_0000;
    end else begin
      div_cnt <= div_cnt + 23'h00_0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      test_sel <= `SEL_X1;
      elapsed <= 10'h000;
      run_total <= 12'h000;
      msg_left <= 2'h0;
      cause <= `FN_LD;
      func_led <= 4'h0;
      pointer <= `PTR_PHASE_A;
      disp_mode <= `DISP_BLANK;
      disp_value <= 16'h0000;
      trip_cmd <= 1'b0;
      events <= 4'h0;
    end else begin
      trip_cmd <= 1'b0;
      events <= 4'h0;
      if (abort) begin
        // abandon test, clear its indication
        state <= S_IDLE;
        disp_mode <= `DISP_BLANK;
        events[`IRQ_ABORT] <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            if (test_press && ctrl_pwr) begin
              state <= S_ARMED;
              test_sel <= selector;
            end else if (reset_rel && ctrl_pwr) begin
              // no power: cause leds stay lit on battery
              func_led <= 4'h0;
            end
            if (step_press) begin
              pointer <= pointer + 2'h1;
            end
          end
          S_ARMED: begin
            if (test_rel) begin
              // test begins on release
              state <= S_RUN;
              test_sel <= selector;
              elapsed <= 10'h000;
              run_total <= 12'h000;
              disp_mode <= `DISP_TIME;
              disp_value <= 16'h0000;
            end
          end
          S_RUN: begin
            if (tick) begin
              // shown clock wraps past 99.9 s
              elapsed <= (elapsed == `ELAPSED_MAX) ? 10'h000 : elapsed + 10'h001;
              disp_value <= (elapsed == `ELAPSED_MAX) ? 16'h0000 : {6'h00, elapsed + 10'h001};
              run_total <= run_total + 12'h001;
            end
            if (below == 4'h0) begin
              // nothing would act
              state <= S_IDLE;
              disp_mode <= `DISP_BLANK;
              events[`IRQ_DONE] <= 1'b1;
            end else if (reach && trip_pos) begin
              state <= S_DONE_TRIP;
              trip_cmd <= 1'b1;
              func_led <= func_led | (4'h1 << act_fn);
              cause <= act_fn;
              disp_mode <= `DISP_MSG;
              disp_value <= {14'h0000, act_fn};
              msg_left <= (act_fn == `FN_LD) ? 2'h2 : 2'h1;
              events[`IRQ_TRIP] <= 1'b1;
            end else if (reach) begin
              // no-trip: leds of each function under test level, would-be delay
              state <= S_DONE_NT;
              func_led <= func_led | below;
              disp_mode <= `DISP_TIME;
              disp_value <= {4'h0, act_delay};
              events[`IRQ_DONE] <= 1'b1;
            end
          end
          S_DONE_NT: begin
            if (step_press) begin
              // delay value stays, no current shown
              pointer <= pointer + 2'h1;
            end
            if (reset_rel && ctrl_pwr) begin
              state <= S_IDLE;
              func_led <= 4'h0;
              disp_mode <= `DISP_BLANK;
              disp_value <= 16'h0000;
            end
          end
          S_DONE_TRIP: begin
            if (step_press) begin
              if (msg_left != 2'h0) begin
                msg_left <= msg_left - 2'h1;
              end else begin
                pointer <= pointer + 2'h1;
              end
            end
            // code first, then current at the matching pointer
            if (msg_left != 2'h0) begin
              disp_mode <= `DISP_MSG;
              disp_value <= {14'h0000, cause};
            end else if (ptr_ok) begin
              disp_mode <= `DISP_CURRENT;
              disp_value <= test_current;
            end else begin
              disp_mode <= `DISP_BLANK;
            end
            if (reset_rel && ctrl_pwr) begin
              state <= S_IDLE;
              func_led <= 4'h0;
              disp_mode <= `DISP_BLANK;
              disp_value <= 16'h0000;
              pointer <= `PTR_PHASE_A;
              msg_left <= 2'h0;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
      if (fault_trip) begin
        // protection wins over any test, cause leds win over a clear
        trip_cmd <= 1'b1;
        events[`IRQ_FAULT] <= 1'b1;
        func_led <= func_led | fault_cause;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pickup_ld <= `RST_PICKUP;
      pickup_sd <= `RST_PICKUP;
      pickup_inst <= `RST_PICKUP;
      pickup_gnd <= `RST_PICKUP;
      delay_ld <= `RST_DELAY;
      delay_sd <= `RST_DELAY;
      delay_gnd <= `RST_DELAY;
      plug <= `RST_PLUG;
      int_mask <= `RST_MASK;
    end else if (wr) begin
      case (addr)
        `REG_PICKUP_LD: pickup_ld <= wdata[7:0];
        `REG_PICKUP_SD: pickup_sd <= wdata[7:0];
        `REG_PICKUP_INST: pickup_inst <= wdata[7:0];
        `REG_PICKUP_GND: pickup_gnd <= wdata[7:0];
        `REG_DELAY_LD: delay_ld <= wdata[11:0];
        `REG_DELAY_SD: delay_sd <= wdata[11:0];
        `REG_DELAY_GND: delay_gnd <= wdata[11:0];
        `REG_PLUG: plug <= wdata[7:0];
        `REG_INT_MASK: int_mask <= wdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky events, read clears, new event wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= 4'h0;
    end else if (rd && addr == `REG_INT_STAT) begin
      int_stat <= events;
    end else begin
      int_stat <= int_stat | events;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `REG_PICKUP_LD: rdata <= {24'h00_0000, pickup_ld};
        `REG_PICKUP_SD: rdata <= {24'h00_0000, pickup_sd};
        `REG_PICKUP_INST: rdata <= {24'h00_0000, pickup_inst};
        `REG_PICKUP_GND: rdata <= {24'h00_0000, pickup_gnd};
        `REG_DELAY_LD: rdata <= {20'h0_0000, delay_ld};
        `REG_DELAY_SD: rdata <= {20'h0_0000, delay_sd};
        `REG_DELAY_GND: rdata <= {20'h0_0000, delay_gnd};
        `REG_PLUG: rdata <= {24'h00_0000, plug};
        `REG_STATUS: rdata <= {21'h00_0000, state, msg_left, pointer, func_led};
        `REG_ELAPSED: rdata <= {20'h0_0000, run_total};
        `REG_INT_STAT: rdata <= {28'h000_0000, int_stat};
        `REG_INT_MASK: rdata <= {28'h000_0000, int_mask};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// [trip_unit_test_panel_sequencer_assertions.sv]
// concurrent checks on the ports of the front-panel test sequencer
`timescale 1ns/10ps
`include "panel_defines.vh"
module trip_unit_test_panel_sequencer_assertions #(
  parameter TICK_CYCLES = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // panel and plant inputs
  input wire [2:0] selector,
  input wire test_btn,
  input wire reset_btn,
  input wire batt_check_btn,
  input wire batt_ok,
  input wire ctrl_pwr,
  input wire fault_trip,
  input wire [3:0] fault_cause,
  // panel and breaker outputs
  input wire [3:0] func_led,
  input wire [1:0] disp_mode,
  input wire [15:0] disp_value,
  input wire test_msg,
  input wire batt_led,
  input wire trip_cmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // display shows the running clock
  wire timing = disp_mode == `DISP_TIME;
  ////////////////////////////////////////////////////////////////////////////
  chk_run_zero: assert property (timing && !$past(timing) |-> disp_value == 16'h0000)
    else $error("run clock not started at zero");
  chk_run_step: assert property (timing && $past(timing) && $stable(func_led) |->
    disp_value == $past(disp_value) || disp_value == $past(disp_value) + 16'h0001 ||
    ($past(disp_value) == `ELAPSED_MAX && disp_value == 16'h0000))
    else $error("run clock jumped");
  chk_run_max: assert property (timing |-> disp_value <= 16'h03E7)
    else $error("run clock above its limit");
  chk_msg_held: assert property (test_msg |-> $past(test_btn) || $past(test_btn, 2) ||
    $past(test_btn, 3)) else $error("test message without held button");
  chk_trip_pos: assert property (trip_cmd && !$past(fault_trip) |->
    selector == `SEL_PHASE_TRIP || selector == `SEL_GND_TRIP)
    else $error("test trip from a no-trip position");
  chk_trip_once: assert property (trip_cmd && $past(trip_cmd) |-> $past(fault_trip))
    else $error("test trip longer than one cycle");
  chk_fault_trip: assert property (fault_trip |=> trip_cmd &&
    (func_led & $past(fault_cause)) == $past(fault_cause)) else $error("real fault ignored");
  chk_batt_led: assert property (batt_led == (batt_check_btn & batt_ok))
    else $error("battery led wrong");
  chk_leds_kept: assert property (!ctrl_pwr && !fault_trip |=> $stable(func_led))
    else $error("leds changed without control power");
  chk_reset_clear: assert property ($fell(reset_btn) && ctrl_pwr && !fault_trip |->
    ##[1:4] func_led == 4'h0 && disp_mode == `DISP_BLANK) else $error("trip reset no clear");
  // main scenarios reached
  cov_trip: cover property (trip_cmd && !$past(fault_trip));
  cov_current: cover property (disp_mode == `DISP_CURRENT);
  cov_wrap: cover property (timing && $past(disp_value) == `ELAPSED_MAX && disp_value == 0);
endmodule
bind trip_unit_test_panel_sequencer trip_unit_test_panel_sequencer_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (
  .clk, .rstn, .selector, .test_btn, .reset_btn, .batt_check_btn, .batt_ok, .ctrl_pwr,
  .fault_trip, .fault_cause, .func_led, .disp_mode, .disp_value, .test_msg, .batt_led,
  .trip_cmd
);

// [trip_unit_test_panel_sequencer_bench.sv]
// self-checking bench of the front-panel test sequencer
`timescale 1ns/10ps
`include "panel_defines.vh"
module trip_unit_test_panel_sequencer_bench;
  localparam int TK = 4; // shortened tenth-second tick
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [5:0] addr = 6'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [2:0] selector = 3'h0;
  reg batt_ok = 1'b0;
  reg ctrl_pwr = 1'b1;
  reg [7:0] load_pct = 8'h00;
  reg fault_trip = 1'b0;
  reg [3:0] fault_cause = 4'h0;
  reg [15:0] last_v = 16'h0000;
  wire [31:0] rdata;
  wire [3:0] func_led;
  wire [1:0] pointer, disp_mode;
  wire [15:0] disp_value;
  wire test_msg, batt_led, trip_cmd, irq, test_btn, step_btn, reset_btn, batt_check_btn;
  int err_total = 0;
  int num_checks = 0;
  int trips = 0;
  bit wrapped = 1'b0;
  // no-trip positions and their simulated levels
  bit [2:0] nts[6] = '{`SEL_X1, `SEL_X2, `SEL_X3, `SEL_X8, `SEL_X10, `SEL_GND_CHECK};
  bit [7:0] ntl[6] = '{`LVL_X1, `LVL_X2, `LVL_X3, `LVL_X8, `LVL_X10, `LVL_GND};
  always #10 clk = ~clk;
  trip_unit_test_panel_sequencer #(.TICK_CYCLES(TK)) i_dut (
    .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .selector, .test_btn, .step_btn,
    .reset_btn, .batt_check_btn, .batt_ok, .ctrl_pwr, .load_pct, .fault_trip, .fault_cause,
    .func_led, .pointer, .disp_mode, .disp_value, .test_msg, .batt_led, .trip_cmd, .irq
  );
  panel_operator i_op (.clk, .test_btn, .step_btn, .reset_btn, .batt_check_btn);
  ////////////////////////////////////////////////////////////////////////////
  // trip count and run clock rollover seen at the display
  always @(posedge clk) begin
    last_v <= disp_value;
    if (trip_cmd === 1'b1) trips <= trips + 1;
    if (disp_mode === `DISP_TIME && last_v === 16'h03E7 && disp_value === 16'h0000)
      wrapped <= 1'b1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle register write and read
  task wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // wait for a lit function led, bounded
  task wled(input int n);
    int i;
    i = 0;
    while (func_led === 4'h0 && i < n) begin
      @(posedge clk);
      i++;
    end
    #1;
  endtask
  task wrap_up;
    $display("checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] p, pl, lv;
    logic [11:0] d;
    logic [5:0] g;
    logic [3:0] e;
    int s, k, i;
    s = $urandom(32'h1132_1333);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wt(3);
    // reset values and an unmapped place
    rreg(`REG_PICKUP_LD, 32'h0000_00FF);
    rreg(`REG_DELAY_LD, 32'h0000_0000);
    rreg(`REG_PLUG, 32'h0000_0000);
    rreg(`REG_INT_MASK, 32'h0000_0000);
    rreg(6'h30 + 6'($urandom % 4) * 6'h04, 32'h0000_0000);
    // no-trip positions, load at or below the abort limit
    for (k = 0; k < 6; k++) begin
      lv = ntl[k];
      load_pct <= (k == 0) ? 8'h28 : 8'($urandom % 8'h29);
      p = (k == 0) ? lv - 8'h01 : (k == 1) ? lv : 8'h01 + $urandom % 8'h3C;
      d = 12'h001 + $urandom % 5;
      g = (k == 5) ? `REG_PICKUP_GND : `REG_PICKUP_LD;
      e = (p < lv) ? ((k == 5) ? 4'h8 : 4'h1) : 4'h0;
      wreg(g, p);
      wreg((k == 5) ? `REG_DELAY_GND : `REG_DELAY_LD, d);
      selector <= nts[k];
      i_op.push(0);
      wled(60);
      chk(func_led, e);
      if (e != 0) chk(disp_value, d);
      i_op.hold(1, 1'($urandom % 2)); // one or two step presses
      i_op.hold(1, 1'b0);
      i_op.push(1);
      if (e != 0) chk({disp_mode == `DISP_CURRENT, disp_value}, {1'b0, 4'h0, d});
      i_op.push(2);
      chk({func_led, disp_mode}, {4'h0, `DISP_BLANK});
      if (k == 5) wreg(g, 32'h0000_00FF);
    end
    chk(trips, 0);
    // done events latched, then unmasked and cleared by a read
    chk(irq, 0);
    wreg(`REG_INT_MASK, 32'h0000_0001);
    #1 chk(irq, 1);
    rreg(`REG_INT_STAT, 32'h0000_0001);
    chk(irq, 0);
    // long run past the display limit, then aborted
    wreg(`REG_PICKUP_LD, 32'h0000_0005);
    wreg(`REG_DELAY_LD, 32'h0000_03F2);
    selector <= `SEL_X1;
    i_op.push(0);
    i = 0;
    while (!wrapped && i < 4200) begin
      @(posedge clk);
      i++;
    end
    chk(wrapped, 1);
    i_op.push(2);
    chk(disp_mode, `DISP_BLANK);
    rreg(`REG_INT_STAT, 32'h0000_0004);
    // abort by trip reset, by load above the limit, by a real fault
    wreg(`REG_DELAY_LD, 32'h0000_0032);
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      load_pct <= 8'h28;
      selector <= nts[$urandom % 5];
      i_op.push(0);
      wt(10);
      @(posedge clk);
      if (k == 1) load_pct <= 8'h29;
      if (k == 2) fault_cause <= 4'h1 + $urandom % 15;
      if (k == 2) fault_trip <= 1'b1;
      @(posedge clk);
      fault_trip <= 1'b0;
      if (k == 0) i_op.hold(2, 1'b1);
      wt(4);
      chk(disp_mode, `DISP_BLANK);
      rreg(`REG_INT_STAT, (k == 2) ? 32'h0000_000C : 32'h0000_0004);
      if (k == 0) i_op.hold(2, 1'b0);
      else i_op.push(2);
    end
    // trip tests: long delay, short delay, instantaneous, ground
    for (k = 0; k < 4; k++) begin
      lv = (k == 3) ? `LVL_GND : `LVL_X6;
      pl = 8'h01 + $urandom % 8'hFF;
      for (i = 0; i < 4; i++) wreg(6'(i * 4), 32'h0000_00FF);
      wreg(6'(k * 4), lv >> 1);
      wreg((k == 3) ? `REG_DELAY_GND : `REG_DELAY_LD + 6'(k * 4), 32'h0000_0002);
      wreg(`REG_PLUG, pl);
      selector <= (k == 3) ? `SEL_GND_TRIP : `SEL_PHASE_TRIP;
      s = trips;
      i_op.hold(0, 1'b1);
      chk({test_msg, disp_mode}, {1'b1, `DISP_BLANK});
      i_op.hold(0, 1'b0);
      if (k != 2) chk(disp_mode, `DISP_TIME);
      wled(60);
      chk(trips - s, 1);
      chk({func_led, disp_mode, disp_value}, {4'h1 << k, `DISP_MSG, 16'(k)});
      i_op.push(1);
      if (k == 0) chk(disp_mode == `DISP_CURRENT, 0);
      if (k == 0) i_op.push(1);
      i = 0;
      while (pointer !== ((k == 3) ? `PTR_GROUND : `PTR_PHASE_A) && i < 5) begin
        i_op.push(1);
        i++;
      end
      chk({disp_mode, disp_value}, {`DISP_CURRENT, 16'(lv) * 16'(pl)});
      i_op.push(1);
      chk(disp_mode != `DISP_TIME, 1);
      @(posedge clk);
      ctrl_pwr <= 1'b0;
      i_op.push(2);
      chk(func_led, 4'h1 << k);
      @(posedge clk);
      ctrl_pwr <= 1'b1;
      i_op.push(2);
      chk({func_led, disp_mode, pointer}, {4'h0, `DISP_BLANK, `PTR_PHASE_A});
    end
    // battery check, every cell and button pair, with random plant faults
    e = 4'($urandom);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      batt_ok <= k[0] ^ e[0];
      ctrl_pwr <= k[1] ^ e[1];
      fault_cause <= e;
      fault_trip <= k[0] ^ e[2];
      i_op.hold(3, k[1] ^ e[3]);
      chk(batt_led, (k[0] ^ e[0]) & (k[1] ^ e[3]));
      @(posedge clk);
      fault_trip <= 1'b0;
      i_op.hold(3, 1'b0);
      chk(func_led, (k[0] ^ e[2]) ? e : 4'h0);
      @(posedge clk);
      ctrl_pwr <= 1'b1;
      i_op.push(2);
    end
    wrap_up;
  end
endmodule
